// file: charger_ctrl_map.svh
// register map, reset values and decode tables of the charger control bank
`ifndef CHARGER_CTRL_MAP_SVH
`define CHARGER_CTRL_MAP_SVH

`define CCR_ADDR_MAIN      8'h04
`define CCR_ADDR_COLD      8'h05
`define CCR_RESET_MAIN     8'h02
`define CCR_RESET_COLD     8'h20
`define CCR_MASK_MAIN      8'h7F
`define CCR_ZERO_BYTE      8'h00

`define CCR_PCT_FULL       7'h64
`define CCR_PCT_REDUCED    7'h5A

`define CCR_HRS_BASE       4'h2
`define CCR_HRS_CODE6      4'h8
`define CCR_HRS_CODE7      4'hA
`define CCR_TIMER_CODE6    3'h6
`define CCR_TIMER_CODE7    3'h7

`define CCR_TEMP_C0        8'hF6
`define CCR_TEMP_C1        8'h00
`define CCR_TEMP_C2        8'h0A
`define CCR_TEMP_C3        8'h0F
`define CCR_TEMP_C4        8'h28
`define CCR_TEMP_C5        8'h2D
`define CCR_TEMP_C6        8'h32
`define CCR_TEMP_C7        8'h3C

`define CCR_MV_C0          12'h7D0
`define CCR_MV_C1          12'h802
`define CCR_MV_C2          12'h81B
`define CCR_MV_C3          12'h834

`define CCR_PM_C0          10'h000
`define CCR_PM_C1          10'h0FA
`define CCR_PM_C2          10'h177
`define CCR_PM_C3          10'h1F4
`define CCR_PM_C4          10'h271
`define CCR_PM_C5          10'h2EE
`define CCR_PM_C6          10'h36B
`define CCR_PM_C7          10'h3E8

`endif

// file: charger_ctrl_pkg.sv
// types of the charger control bank
package charger_ctrl_pkg;

    typedef struct packed {
        logic       reserved;
        logic       battery_discharge_limit_sel;
        logic       adapter_current_limit_sel;
        logic [2:0] fast_charge_timer_sel;
        logic       external_charge_pin_select;
        logic       charger_on;
    } charger_control_main_s;

    typedef struct packed {
        logic [2:0] first_temp_threshold;
        logic [1:0] cold_range_term_voltage;
        logic [2:0] cold_range_charge_current;
    } charger_cold_range_setup_s;

    typedef struct packed {
        logic [6:0]  battery_limit_pct;
        logic [6:0]  adapter_limit_pct;
        logic [3:0]  timer_hours;
        logic [7:0]  first_temp_c;
        logic [11:0] term_voltage_mv;
        logic [9:0]  charge_current_permille;
    } charger_settings_s;

    typedef struct packed {
        charger_control_main_s     main;
        charger_cold_range_setup_s cold;
        logic [7:0]                rdata;
        logic                      pin_meta;
        logic                      pin_sync;
        logic                      charge_enable;
    } bank_state_s;

endpackage

// file: charger_setting_decode.sv
// turns the raw register fields into the values the analog loop consumes
`timescale 1ns/10ps
`include "charger_ctrl_map.svh"

module charger_setting_decode
    import charger_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_reset,
    input  wire logic                      i_clock_enable,
    // raw fields
    input  wire charger_control_main_s     i_main,
    input  wire charger_cold_range_setup_s i_cold,
    // decoded values
    output charger_settings_s              o_settings
);

    charger_settings_s state_q;
    charger_settings_s state_d;

    always_comb begin
        state_d = state_q;
        state_d.battery_limit_pct = i_main.battery_discharge_limit_sel ?
            `CCR_PCT_REDUCED : `CCR_PCT_FULL;
        state_d.adapter_limit_pct = i_main.adapter_current_limit_sel ?
            `CCR_PCT_REDUCED : `CCR_PCT_FULL;
        // upper two codes taken as 8 h and 10 h in code order
        unique case (i_main.fast_charge_timer_sel)
            `CCR_TIMER_CODE6: state_d.timer_hours = `CCR_HRS_CODE6;
            `CCR_TIMER_CODE7: state_d.timer_hours = `CCR_HRS_CODE7;
            default: state_d.timer_hours = `CCR_HRS_BASE
                + {1'b0, i_main.fast_charge_timer_sel};
        endcase
        unique case (i_cold.first_temp_threshold)
            3'h0: state_d.first_temp_c = `CCR_TEMP_C0;
            3'h1: state_d.first_temp_c = `CCR_TEMP_C1;
            3'h2: state_d.first_temp_c = `CCR_TEMP_C2;
            3'h3: state_d.first_temp_c = `CCR_TEMP_C3;
            3'h4: state_d.first_temp_c = `CCR_TEMP_C4;
            3'h5: state_d.first_temp_c = `CCR_TEMP_C5;
            3'h6: state_d.first_temp_c = `CCR_TEMP_C6;
            3'h7: state_d.first_temp_c = `CCR_TEMP_C7;
        endcase
        unique case (i_cold.cold_range_term_voltage)
            2'h0: state_d.term_voltage_mv = `CCR_MV_C0;
            2'h1: state_d.term_voltage_mv = `CCR_MV_C1;
            2'h2: state_d.term_voltage_mv = `CCR_MV_C2;
            2'h3: state_d.term_voltage_mv = `CCR_MV_C3;
        endcase
        unique case (i_cold.cold_range_charge_current)
            3'h0: state_d.charge_current_permille = `CCR_PM_C0;
            3'h1: state_d.charge_current_permille = `CCR_PM_C1;
            3'h2: state_d.charge_current_permille = `CCR_PM_C2;
            3'h3: state_d.charge_current_permille = `CCR_PM_C3;
            3'h4: state_d.charge_current_permille = `CCR_PM_C4;
            3'h5: state_d.charge_current_permille = `CCR_PM_C5;
            3'h6: state_d.charge_current_permille = `CCR_PM_C6;
            3'h7: state_d.charge_current_permille = `CCR_PM_C7;
        endcase
    end

    // reset value matches the decode of the register reset codes
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q <= '{`CCR_PCT_FULL, `CCR_PCT_FULL, `CCR_HRS_BASE,
                         `CCR_TEMP_C1, `CCR_MV_C0, `CCR_PM_C0};
        end else if (i_clock_enable) begin
            state_q <= state_d;
        end
    end

    assign o_settings = state_q;

    property p_battery_pct;
        @(posedge i_clock) disable iff (i_reset)
        i_clock_enable |=> o_settings.battery_limit_pct ==
            ($past(i_main.battery_discharge_limit_sel) ? 7'h5A : 7'h64);
    endproperty
    a_battery_pct: assert property (p_battery_pct) else $error("battery limit wrong");

    property p_adapter_pct;
        @(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && i_main.adapter_current_limit_sel) |=>
            o_settings.adapter_limit_pct == 7'h5A;
    endproperty
    a_adapter_pct: assert property (p_adapter_pct) else $error("adapter limit wrong");

    property p_timer_hours;
        @(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && i_main.fast_charge_timer_sel < 3'h6) |=>
            o_settings.timer_hours == 4'h2 + {1'b0, $past(i_main.fast_charge_timer_sel)};
    endproperty
    a_timer_hours: assert property (p_timer_hours) else $error("timer hours wrong");

    property p_temp_top;
        @(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && i_cold.first_temp_threshold == 3'h7) |=>
            o_settings.first_temp_c == 8'h3C;
    endproperty
    a_temp_top: assert property (p_temp_top) else $error("threshold code 7 wrong");

    property p_volt_code2;
        @(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && i_cold.cold_range_term_voltage == 2'h2) |=>
            o_settings.term_voltage_mv == 12'h81B;
    endproperty
    a_volt_code2: assert property (p_volt_code2) else $error("voltage code 2 wrong");

    property p_current_full;
        @(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && i_cold.cold_range_charge_current == 3'h7) |=>
            o_settings.charge_current_permille == 10'h3E8;
    endproperty
    a_current_full: assert property (p_current_full) else $error("current code 7 wrong");

endmodule

// file: charger_control_registers.sv
// charger control register bank with decoded outputs
`timescale 1ns/10ps
`include "charger_ctrl_map.svh"

module charger_control_registers
    import charger_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_reset,
    input  wire logic          i_clock_enable,
    // register port from the serial bus engine
    input  wire logic [7:0]    i_reg_addr,
    input  wire logic          i_reg_write,
    input  wire logic [7:0]    i_reg_wdata,
    input  wire logic          i_reg_read,
    output logic [7:0]         o_reg_rdata,
    // external charge enable pin
    input  wire logic          i_ext_charge_pin,
    // charger controls
    output logic               o_charge_enable,
    output charger_settings_s  o_settings
);

    bank_state_s state_q;
    bank_state_s state_d;
    logic        hit_main;
    logic        hit_cold;

    assign hit_main = (i_reg_addr == `CCR_ADDR_MAIN);
    assign hit_cold = (i_reg_addr == `CCR_ADDR_COLD);

    always_comb begin
        state_d = state_q;
        // pin is asynchronous; only pin_sync is read
        state_d.pin_meta = i_ext_charge_pin;
        state_d.pin_sync = state_q.pin_meta;
        if (i_reg_write && hit_main) begin
            state_d.main = charger_control_main_s'(i_reg_wdata & `CCR_MASK_MAIN);
        end
        if (i_reg_write && hit_cold) begin
            state_d.cold = charger_cold_range_setup_s'(i_reg_wdata);
        end
        if (i_reg_read) begin
            // unmapped addresses read as zero
            state_d.rdata = hit_main ? (8'(state_q.main) & `CCR_MASK_MAIN) :
                            hit_cold ? 8'(state_q.cold) : `CCR_ZERO_BYTE;
        end
        // pin takes over completely when selected, charger_on then ignored
        state_d.charge_enable = state_q.main.external_charge_pin_select ?
            state_q.pin_sync : state_q.main.charger_on;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q.main          <= charger_control_main_s'(`CCR_RESET_MAIN);
            state_q.cold          <= charger_cold_range_setup_s'(`CCR_RESET_COLD);
            state_q.rdata         <= `CCR_ZERO_BYTE;
            state_q.pin_meta      <= 1'b0;
            state_q.pin_sync      <= 1'b0;
            state_q.charge_enable <= 1'b0;
        end else if (i_clock_enable) begin
            state_q <= state_d;
        end
    end

    assign o_reg_rdata     = state_q.rdata;
    assign o_charge_enable = state_q.charge_enable;

    charger_setting_decode u_decode (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_main         (state_q.main),
        .i_cold         (state_q.cold),
        .o_settings     (o_settings)
    );

    sequence s_main_write;
        i_clock_enable && i_reg_write && hit_main;
    endsequence

    sequence s_main_readback;
        i_clock_enable && i_reg_read && hit_main && !i_reg_write;
    endsequence

    property p_reserved_zero;
        @(posedge i_clock) disable iff (i_reset)
        // host may leave a few idle cycles between a write and its readback
        s_main_write ##[1:4] s_main_readback |=> o_reg_rdata[7] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read set");

    property p_reset_values;
        @(posedge i_clock)
        $fell(i_reset) |-> state_q.main.external_charge_pin_select == 1'b1 &&
            state_q.main.charger_on == 1'b0 && state_q.cold.first_temp_threshold == 3'h1;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");

    property p_on_write;
        @(posedge i_clock) disable iff (i_reset)
        s_main_write |=> state_q.main.charger_on == $past(i_reg_wdata[0]);
    endproperty
    a_on_write: assert property (p_on_write) else $error("charger_on not stored");

    property p_enable_pin;
        @(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && state_q.main.external_charge_pin_select) |=>
            o_charge_enable == $past(state_q.pin_sync);
    endproperty
    a_enable_pin: assert property (p_enable_pin) else $error("pin not followed");

    property p_enable_reg;
        @(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && !state_q.main.external_charge_pin_select) |=>
            o_charge_enable == $past(state_q.main.charger_on);
    endproperty
    a_enable_reg: assert property (p_enable_reg) else $error("charger_on not followed");

    sequence s_cold_write;
        i_clock_enable && i_reg_write && hit_cold;
    endsequence

    sequence s_cold_read;
        i_clock_enable && i_reg_read && hit_cold && !i_reg_write;
    endsequence

    sequence s_stray_read;
        i_clock_enable && i_reg_read && !hit_main && !hit_cold;
    endsequence

    sequence s_stray_write;
        i_clock_enable && i_reg_write && !hit_main && !hit_cold;
    endsequence

    sequence s_enabled;
        i_clock_enable;
    endsequence

    sequence s_pin_mode;
        i_clock_enable && state_q.main.external_charge_pin_select;
    endsequence

    property p_main_store;
        @(posedge i_clock) disable iff (i_reset)
        s_main_write |=> 8'(state_q.main) == ($past(i_reg_wdata) & `CCR_MASK_MAIN);
    endproperty
    a_main_store: assert property (p_main_store) else $error("main not stored");

    property p_cold_store;
        @(posedge i_clock) disable iff (i_reset)
        s_cold_write |=> 8'(state_q.cold) == $past(i_reg_wdata);
    endproperty
    a_cold_store: assert property (p_cold_store) else $error("cold not stored");

    property p_main_read;
        @(posedge i_clock) disable iff (i_reset)
        s_main_readback |=> o_reg_rdata == 8'($past(state_q.main));
    endproperty
    a_main_read: assert property (p_main_read) else $error("main readback wrong");

    property p_cold_read;
        @(posedge i_clock) disable iff (i_reset)
        s_cold_read |=> o_reg_rdata == 8'($past(state_q.cold));
    endproperty
    a_cold_read: assert property (p_cold_read) else $error("cold readback wrong");

    // unmapped places read as zeros so a stale byte never looks valid
    property p_stray_read;
        @(posedge i_clock) disable iff (i_reset)
        s_stray_read |=> o_reg_rdata == `CCR_ZERO_BYTE;
    endproperty
    a_stray_read: assert property (p_stray_read) else $error("unmapped read not zero");

    property p_stray_write;
        @(posedge i_clock) disable iff (i_reset)
        s_stray_write |=> $stable(state_q.main) && $stable(state_q.cold);
    endproperty
    a_stray_write: assert property (p_stray_write) else $error("unmapped write landed");

    property p_frozen;
        @(posedge i_clock) disable iff (i_reset)
        !i_clock_enable |=> $stable(state_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while frozen");

    property p_rdata_hold;
        @(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && !i_reg_read) |=> $stable(o_reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data not held");

    property p_pin_chain;
        @(posedge i_clock) disable iff (i_reset)
        i_clock_enable |=> state_q.pin_meta == $past(i_ext_charge_pin) &&
            state_q.pin_sync == $past(state_q.pin_meta);
    endproperty
    a_pin_chain: assert property (p_pin_chain) else $error("pin chain broken");

    // three enabled edges from pin to output: two sync stages and the output flop
    property p_pin_latency;
        @(posedge i_clock) disable iff (i_reset)
        s_enabled ##1 s_enabled ##1 s_pin_mode |=>
            o_charge_enable == $past(i_ext_charge_pin, 3);
    endproperty
    a_pin_latency: assert property (p_pin_latency) else $error("pin latency wrong");

    property p_reset_outputs;
        @(posedge i_clock)
        $fell(i_reset) |-> o_charge_enable == 1'b0 && o_reg_rdata == `CCR_ZERO_BYTE;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("bad reset outputs");

    property p_reset_settings;
        @(posedge i_clock)
        $fell(i_reset) |-> o_settings.timer_hours == `CCR_HRS_BASE &&
            o_settings.first_temp_c == `CCR_TEMP_C1 &&
            o_settings.battery_limit_pct == `CCR_PCT_FULL;
    endproperty
    a_reset_settings: assert property (p_reset_settings) else $error("bad reset decode");

endmodule

// file: host_port_model.sv
// host side model driving the register port of the charger bank
`timescale 1ns/10ps

module host_port_model (
    // clock
    input  wire logic       i_clock,
    // register port
    output logic [7:0]      o_reg_addr,
    output logic            o_reg_write,
    output logic [7:0]      o_reg_wdata,
    output logic            o_reg_read,
    input  wire logic [7:0] i_reg_rdata
);
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_write = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_read  = 1'b0;
    end

    // one idle edge first, so a strobe is never lowered and raised in one step
    task automatic start_op(input logic [7:0] addr);
        @(posedge i_clock);
        #1;
        o_reg_addr = addr;
    endtask

    // released lines show the inverse, a stale value never looks valid
    task automatic end_op();
        @(posedge i_clock);
        #1;
        o_reg_write = 1'b0;
        o_reg_read  = 1'b0;
        o_reg_addr  = ~o_reg_addr;
        o_reg_wdata = ~o_reg_wdata;
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        start_op(addr);
        o_reg_wdata = data;
        o_reg_write = 1'b1;
        end_op();
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        start_op(addr);
        o_reg_read = 1'b1;
        end_op();
        data = i_reg_rdata;
    endtask
endmodule

// file: test_charger_control_registers.sv
// self-checking testbench of the charger control register bank
`timescale 1ns/10ps

module test_charger_control_registers
    import charger_ctrl_pkg::*;
;
    logic              clock        = 1'b0;
    logic              reset        = 1'b1;
    logic              clock_enable = 1'b1;
    logic              charge_pin   = 1'b0;
    logic [7:0]        reg_addr;
    logic              reg_write;
    logic [7:0]        reg_wdata;
    logic              reg_read;
    logic [7:0]        reg_rdata;
    logic              charge_enable;
    charger_settings_s settings;
    logic [7:0]        rd;
    logic [7:0]        m;
    logic [7:0]        c;
    int                miscompares  = 0;
    int                total_checks = 0;
    logic [7:0]        temp_t [8] = '{8'hF6, 8'h00, 8'h0A, 8'h0F, 8'h28, 8'h2D, 8'h32, 8'h3C};
    logic [11:0]       mv_t [4]   = '{12'h7D0, 12'h802, 12'h81B, 12'h834};
    logic [9:0]        pm_t [8]   = '{10'h000, 10'h0FA, 10'h177, 10'h1F4,
                                      10'h271, 10'h2EE, 10'h36B, 10'h3E8};

    always #4 clock = ~clock;

    charger_control_registers DUT (
        .i_clock          (clock),
        .i_reset          (reset),
        .i_clock_enable   (clock_enable),
        .i_reg_addr       (reg_addr),
        .i_reg_write      (reg_write),
        .i_reg_wdata      (reg_wdata),
        .i_reg_read       (reg_read),
        .o_reg_rdata      (reg_rdata),
        .i_ext_charge_pin (charge_pin),
        .o_charge_enable  (charge_enable),
        .o_settings       (settings)
    );

    host_port_model host (
        .i_clock     (clock),
        .o_reg_addr  (reg_addr),
        .o_reg_write (reg_write),
        .o_reg_wdata (reg_wdata),
        .o_reg_read  (reg_read),
        .i_reg_rdata (reg_rdata)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rd);
        check(16'(rd), 16'(exp));
    endtask

    function automatic logic [3:0] hrs(input logic [2:0] code);
        if (code == 3'h6) return 4'h8;
        if (code == 3'h7) return 4'hA;
        return {1'b0, code} + 4'h2;
    endfunction

    // expected decode worked out from the register contents
    task automatic chk(input logic [7:0] em, input logic [7:0] ec);
        check(16'(settings.battery_limit_pct), em[6] ? 16'h005A : 16'h0064);
        check(16'(settings.adapter_limit_pct), em[5] ? 16'h005A : 16'h0064);
        check(16'(settings.timer_hours), 16'(hrs(em[4:2])));
        check(16'(settings.first_temp_c), 16'(temp_t[ec[7:5]]));
        check(16'(settings.term_voltage_mv), 16'(mv_t[ec[4:3]]));
        check(16'(settings.charge_current_permille), 16'(pm_t[ec[2:0]]));
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic reset_test();
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        rdck(8'h04, 8'h02);
        rdck(8'h05, 8'h20);
        check(16'(charge_enable), 16'h0000);
        chk(8'h02, 8'h20);
        $display("test reset done");
    endtask

    initial begin
        #(8 * 3000);
        miscompares++;
        test_done();
    end

    initial begin
        reset_test();
        // every timer code, limit selects toggled, reserved bit always written as one
        for (int i = 0; i < 8; i++) begin
            m = {1'b1, i[0], i[1], i[2:0], 2'b00};
            host.write_reg(8'h04, m);
            tick(2);
            chk(m, 8'h20);
            rdck(8'h04, m & 8'h7F);
        end
        $display("test main fields done");
        for (int i = 0; i < 8; i++) begin
            c = {i[2:0], i[1:0], ~i[2:0]};
            host.write_reg(8'h05, c);
            tick(2);
            chk(m, c);
            rdck(8'h05, c);
        end
        $display("test cold fields done");
        // charger-on alone, then pin control overriding it
        host.write_reg(8'h04, 8'h01);
        tick(2);
        check(16'(charge_enable), 16'h0001);
        host.write_reg(8'h04, 8'h00);
        tick(2);
        check(16'(charge_enable), 16'h0000);
        host.write_reg(8'h04, 8'h02);
        charge_pin = 1'b1;
        tick(3);
        check(16'(charge_enable), 16'h0001);
        host.write_reg(8'h04, 8'h03);
        charge_pin = 1'b0;
        tick(3);
        check(16'(charge_enable), 16'h0000);
        $display("test charge enable done");
        // unmapped place and frozen clock enable leave the bank alone
        host.write_reg(8'h06, 8'hFF);
        host.write_reg(8'h03, 8'hFF);
        rdck(8'h06, 8'h00);
        clock_enable = 1'b0;
        host.write_reg(8'h04, 8'h7C);
        clock_enable = 1'b1;
        rdck(8'h04, 8'h03);
        rdck(8'h05, c);
        $display("test refusals done");
        reset_test();
        test_done();
    end
endmodule
